// *** hdl/sync_serial_port_cfg.svh ***
// constants for the serial port: mode codes, clock divider half periods, widths
`ifndef SYNC_SERIAL_PORT_CFG_SVH
`define SYNC_SERIAL_PORT_CFG_SVH

`define DATA_W          8
`define BIT_CNT_W       4
`define EDGE_CNT_W      5
`define HALF_CNT_W      10
`define BITS_PER_BYTE   4'h8
`define LAST_EDGE       5'h10
`define SLAVE_WRAP_EDGE 5'h0F

`define MODE_DIV4       4'h0
`define MODE_DIV16      4'h1
`define MODE_DIV64      4'h2
`define MODE_TIMER2     4'h3
`define MODE_SLAVE_SEL  4'h4
`define MODE_SLAVE_FREE 4'h5
`define MODE_RELOAD     4'hA

`define HALF_DIV4       10'h002
`define HALF_DIV16      10'h008
`define HALF_DIV64      10'h020

`define RST_BYTE        8'h00

`endif

// *** hdl/sync_serial_port_pkg.sv ***
// types shared by the serial port design and its bench
package sync_serial_port_pkg;

	typedef struct packed {
		logic       port_enable_bit;
		logic [3:0] port_mode_field;
		logic       clock_idle_polarity;
		logic       clock_edge_select;
		logic       input_sample_phase;
		logic       buffer_overwrite_enable;
	} port_cfg_t;

	typedef struct packed {
		logic serial_clock_pin;
		logic data_in_pin;
		logic select_n_pin;
	} pin_in_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_RUN
	} master_state_t;

endpackage : sync_serial_port_pkg

// *** hdl/sync_serial_port.sv ***
// spi-mode serial port with receive staging buffer and master clock generator
`timescale 1ns/100ps
`include "sync_serial_port_cfg.svh"

module byte_stage_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 2
) (
	input  wire logic         i_clk_sys,
	input  wire logic         i_nrst,
	input  wire logic         i_in_valid,
	output logic              o_in_ready,
	input  wire logic [W-1:0] i_in_data,
	output logic              o_out_valid,
	input  wire logic         i_out_ready,
	output logic [W-1:0]      o_out_data
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [W-1:0]  mem_reg [DEPTH];
	logic [PW-1:0] wr_ptr_reg;
	logic [PW-1:0] rd_ptr_reg;
	logic [PW:0]   count_reg;
	wire           push = i_in_valid && o_in_ready;
	wire           pop  = o_out_valid && i_out_ready;

	assign o_in_ready  = (count_reg != (PW+1)'(DEPTH));
	assign o_out_valid = (count_reg != '0);
	assign o_out_data  = mem_reg[rd_ptr_reg];

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			if (push)
				wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
			count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
		end
	end

	// storage needs no reset; count_reg guards every read
	always_ff @(posedge i_clk_sys) begin
		if (push)
			mem_reg[wr_ptr_reg] <= i_in_data;
	end
endmodule : byte_stage_fifo

module sticky_flag #(
	parameter bit RST_VAL = 1'b0
) (
	input  wire logic i_clk_sys,
	input  wire logic i_nrst,
	input  wire logic i_set,
	input  wire logic i_clr,
	output logic      o_flag
);
	// a set and a clear in the same cycle leave the flag set, so no event is lost
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst)
			o_flag <= RST_VAL;
		else if (i_set)
			o_flag <= 1'b1;
		else if (i_clr)
			o_flag <= 1'b0;
	end
endmodule : sticky_flag

module sync_serial_port #(
	parameter int FIFO_DEPTH = 2
) (
	input  wire logic                            i_clk_sys,
	input  wire logic                            i_nrst,
	input  wire sync_serial_port_pkg::port_cfg_t i_cfg,
	input  wire logic [`DATA_W-1:0]              i_baud_reload_reg,
	input  wire logic                            i_timer2_tick,
	input  wire logic                            i_buf_wr,
	input  wire logic [`DATA_W-1:0]              i_buf_wdata,
	input  wire logic                            i_buf_rd,
	input  wire logic                            i_collision_clr,
	input  wire logic                            i_irq_clr,
	input  wire logic                            i_overflow_clr,
	input  wire sync_serial_port_pkg::pin_in_t   i_pins,
	output logic [`DATA_W-1:0]                   o_port_data_buffer,
	output logic                                 o_buffer_full_flag,
	output logic                                 o_write_collision_flag,
	output logic                                 o_port_irq_flag,
	output logic                                 o_receive_overflow,
	output logic                                 o_busy,
	output logic                                 o_serial_clock_pin,
	output logic                                 o_serial_clock_oe_n,
	output logic                                 o_data_out_pin,
	output logic                                 o_data_out_oe_n
);
	sync_serial_port_pkg::master_state_t mst_reg;
	sync_serial_port_pkg::pin_in_t       meta_reg;
	sync_serial_port_pkg::pin_in_t       pin_reg;
	logic                    sck_prev_reg;
	logic [`DATA_W-1:0]      port_shift_reg;
	logic [`DATA_W-1:0]      buf_reg;
	logic [`BIT_CNT_W-1:0]   bit_cnt_reg;
	logic [`EDGE_CNT_W-1:0]  edge_cnt_reg;
	logic [`HALF_CNT_W-1:0]  half_cnt_reg;
	logic                    sck_act_reg;
	logic                    sck_pin_reg;
	logic                    sdo_reg;
	logic                    bf_reg;
	logic                    write_collision_flag_reg;
	logic                    irq_reg;
	logic                    ovf_reg;
	logic                    busy_reg;
	logic                    sck_oe_n_reg;
	logic                    sdo_oe_n_reg;
	logic [`HALF_CNT_W-1:0]  half_len;
	logic                    fifo_in_ready;
	logic                    fifo_out_valid;
	logic [`DATA_W-1:0]      fifo_out_data;

	// role and clock selection from the mode field
	wire enable     = i_cfg.port_enable_bit;
	wire [3:0] mode = i_cfg.port_mode_field;
	wire cke        = i_cfg.clock_edge_select;
	wire is_slave   = (mode == `MODE_SLAVE_SEL) || (mode == `MODE_SLAVE_FREE);
	wire is_master  = enable && !is_slave;
	wire sel_mode   = (mode == `MODE_SLAVE_SEL);
	wire deselected = sel_mode && pin_reg.select_n_pin;
	wire port_reset = !enable || (is_slave && deselected);

	always_comb begin
		case (mode)
			`MODE_DIV16:  half_len = `HALF_DIV16;
			`MODE_DIV64:  half_len = `HALF_DIV64;
			`MODE_RELOAD: half_len = {1'b0, i_baud_reload_reg, 1'b0}
			                         + `HALF_DIV4;
			default:      half_len = `HALF_DIV4;
		endcase
	end

	wire running   = (mst_reg == sync_serial_port_pkg::ST_RUN);
	wire half_done = (mode == `MODE_TIMER2) ? i_timer2_tick
	                                        : (half_cnt_reg == half_len - 1'b1);
	wire m_edge    = is_master && running && half_done;
	// slave edges come only from the synchronised pin, never the first stage
	wire s_edge    = enable && is_slave && !deselected
	                 && (pin_reg.serial_clock_pin != sck_prev_reg);
	wire edge_ev   = m_edge || s_edge;
	wire at_end    = (edge_cnt_reg == `LAST_EDGE);
	wire lead      = !edge_cnt_reg[0];
	// late sampling only for the master; a slave keeps the sample phase clear
	wire smp_m     = i_cfg.input_sample_phase && !is_slave;
	wire samp_ev   = edge_ev && ((smp_m && !cke) ? (lead && edge_cnt_reg != '0)
	                 : (!at_end && (lead == (cke ^ smp_m))));
	wire chg_ev    = edge_ev && !at_end && (cke ? !lead : lead);
	wire byte_done = samp_ev && (bit_cnt_reg == `BITS_PER_BYTE - 1'b1);
	wire xfer_busy = running || (is_slave && (edge_cnt_reg != '0 || bit_cnt_reg != '0));

	// a write is refused whole; nothing of it reaches the buffer or the shifter
	wire wr_try    = i_buf_wr && enable;
	wire wr_ok     = wr_try && !xfer_busy && !write_collision_flag_reg && fifo_in_ready
	                 && (!bf_reg || i_cfg.buffer_overwrite_enable);
	wire pop_ok    = fifo_out_valid && !i_buf_wr
	                 && (!bf_reg || i_cfg.buffer_overwrite_enable);
	// a slave cannot hold off its master, so a byte with no room is lost
	wire rx_drop   = byte_done && !fifo_in_ready;
	// the master toggles only between a start and the closing half period
	wire sck_act_next = (port_reset || wr_ok) ? 1'b0
	                  : (edge_ev && !at_end) ? (is_master && !sck_act_reg) : sck_act_reg;

	wire sck_oe_n_next = !is_master;
	wire sdo_oe_n_next = !enable || (is_slave && deselected);

	byte_stage_fifo #(
		.W     (`DATA_W),
		.DEPTH (FIFO_DEPTH)
	) u_stage (
		.i_clk_sys   (i_clk_sys),
		.i_nrst      (i_nrst),
		.i_in_valid  (byte_done),
		.o_in_ready  (fifo_in_ready),
		.i_in_data   ({port_shift_reg[`DATA_W-2:0], pin_reg.data_in_pin}),
		.o_out_valid (fifo_out_valid),
		.i_out_ready (pop_ok),
		.o_out_data  (fifo_out_data)
	);

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			meta_reg     <= '1;
			pin_reg      <= '1;
			sck_prev_reg <= 1'b1; // matches the synchroniser reset, so no false edge
		end else begin
			meta_reg     <= i_pins;
			pin_reg      <= meta_reg;
			sck_prev_reg <= pin_reg.serial_clock_pin;
		end
	end

	// shift engine: master clock generator, edge counter and shift register
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			mst_reg        <= sync_serial_port_pkg::ST_IDLE;
			port_shift_reg <= `RST_BYTE;
			bit_cnt_reg    <= '0;
			edge_cnt_reg   <= '0;
			half_cnt_reg   <= '0;
			sdo_reg        <= 1'b0;
		end else if (port_reset) begin
			mst_reg      <= sync_serial_port_pkg::ST_IDLE;
			bit_cnt_reg  <= '0;
			edge_cnt_reg <= '0;
			half_cnt_reg <= '0;
		end else if (wr_ok) begin
			port_shift_reg <= i_buf_wdata;
			sdo_reg        <= cke ? i_buf_wdata[`DATA_W-1] : sdo_reg;
			bit_cnt_reg    <= '0;
			edge_cnt_reg   <= '0;
			half_cnt_reg   <= '0;
			mst_reg        <= is_slave ? sync_serial_port_pkg::ST_IDLE
			                           : sync_serial_port_pkg::ST_RUN;
		end else begin
			half_cnt_reg <= (!running || half_done) ? '0 : half_cnt_reg + 1'b1;
			if (samp_ev) begin
				port_shift_reg <= {port_shift_reg[`DATA_W-2:0], pin_reg.data_in_pin};
				bit_cnt_reg    <= byte_done ? '0 : bit_cnt_reg + 1'b1;
			end
			if (chg_ev)
				sdo_reg <= samp_ev ? port_shift_reg[`DATA_W-2] : port_shift_reg[`DATA_W-1];
			if (m_edge && at_end) begin
				mst_reg      <= sync_serial_port_pkg::ST_IDLE;
				edge_cnt_reg <= '0;
			end else if (s_edge) begin
				edge_cnt_reg <= (edge_cnt_reg == `SLAVE_WRAP_EDGE) ? '0 : edge_cnt_reg + 1'b1;
			end else if (m_edge) begin
				edge_cnt_reg <= edge_cnt_reg + 1'b1;
			end
		end
	end

	// software-visible buffer; a write wins over a pop in the same cycle
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst)
			buf_reg <= `RST_BYTE;
		else if (wr_ok)
			buf_reg <= i_buf_wdata;
		else if (pop_ok)
			buf_reg <= fifo_out_data;
	end

	sticky_flag u_full_flag (
		.i_clk_sys (i_clk_sys),
		.i_nrst    (i_nrst),
		.i_set     (pop_ok),
		.i_clr     (i_buf_rd),
		.o_flag    (bf_reg)
	);

	sticky_flag u_collision_flag (
		.i_clk_sys (i_clk_sys),
		.i_nrst    (i_nrst),
		.i_set     (wr_try && !wr_ok),
		.i_clr     (i_collision_clr),
		.o_flag    (write_collision_flag_reg)
	);

	sticky_flag u_irq_flag (
		.i_clk_sys (i_clk_sys),
		.i_nrst    (i_nrst),
		.i_set     (pop_ok),
		.i_clr     (i_irq_clr),
		.o_flag    (irq_reg)
	);

	sticky_flag u_overflow_flag (
		.i_clk_sys (i_clk_sys),
		.i_nrst    (i_nrst),
		.i_set     (rx_drop),
		.i_clr     (i_overflow_clr),
		.o_flag    (ovf_reg)
	);

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			busy_reg     <= 1'b0;
			sck_oe_n_reg <= 1'b1;
			sdo_oe_n_reg <= 1'b1;
			sck_act_reg  <= 1'b0;
			sck_pin_reg  <= 1'b0;
		end else begin
			busy_reg     <= xfer_busy;
			sck_act_reg  <= sck_act_next;
			// polarity folded in at the flop so the pin never glitches through a gate
			sck_pin_reg  <= sck_act_next ^ i_cfg.clock_idle_polarity;
			sck_oe_n_reg <= sck_oe_n_next;
			sdo_oe_n_reg <= sdo_oe_n_next;
		end
	end

	// status outputs are read-only views of internal state
	assign o_port_data_buffer     = buf_reg;
	assign o_buffer_full_flag     = bf_reg;
	assign o_write_collision_flag = write_collision_flag_reg;
	assign o_port_irq_flag        = irq_reg;
	assign o_receive_overflow     = ovf_reg;
	assign o_busy                 = busy_reg;
	assign o_serial_clock_pin     = sck_pin_reg;
	assign o_serial_clock_oe_n    = sck_oe_n_reg;
	assign o_data_out_pin         = sdo_reg;
	assign o_data_out_oe_n        = sdo_oe_n_reg;

endmodule : sync_serial_port

// *** test/sync_serial_port_sva.sv ***
// port-level assertions for the serial port
`timescale 1ns/100ps
`include "sync_serial_port_cfg.svh"
module sync_serial_port_sva #(
	parameter int FIFO_DEPTH = 2
) (
	input wire logic                            i_clk_sys,
	input wire logic                            i_nrst,
	input wire sync_serial_port_pkg::port_cfg_t i_cfg,
	input wire logic                            i_buf_wr,
	input wire logic [`DATA_W-1:0]              i_buf_wdata,
	input wire logic                            i_buf_rd,
	input wire sync_serial_port_pkg::pin_in_t   i_pins,
	input wire logic [`DATA_W-1:0]              o_port_data_buffer,
	input wire logic                            o_buffer_full_flag,
	input wire logic                            o_write_collision_flag,
	input wire logic                            o_port_irq_flag,
	input wire logic                            o_busy,
	input wire logic                            o_serial_clock_pin,
	input wire logic                            o_serial_clock_oe_n,
	input wire logic                            o_data_out_oe_n
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_nrst);
	wire en  = i_cfg.port_enable_bit;
	wire sel = i_cfg.port_mode_field == `MODE_SLAVE_SEL;
	wire slv = sel || i_cfg.port_mode_field == `MODE_SLAVE_FREE;
	wire mst = en && !slv;
	// o_busy lags one cycle, so a second strobe right after a write is excluded
	sequence wr_taken;
		mst && i_buf_wr && !$past(i_buf_wr) && !o_busy && !o_write_collision_flag
			&& !o_buffer_full_flag;
	endsequence
	sequence wr_refused;
		mst && i_buf_wr && !o_busy && o_write_collision_flag;
	endsequence
	wr_load_a: assert property (wr_taken |=> o_port_data_buffer == $past(i_buf_wdata))
		else $error("accepted write did not load the buffer");
	wr_start_a: assert property (wr_taken |=> ##1 o_busy)
		else $error("accepted write did not start a transfer");
	wr_collide_a: assert property (en && i_buf_wr ##1 o_busy |-> o_write_collision_flag)
		else $error("write during transfer did not collide");
	coll_block_a: assert property (wr_refused |=> ##1 !o_busy)
		else $error("write taken while collision flag set");
	rd_clear_a: assert property (i_buf_rd && o_buffer_full_flag && !i_cfg.buffer_overwrite_enable
		|=> !o_buffer_full_flag)
		else $error("read did not clear full flag");
	full_irq_a: assert property ($rose(o_buffer_full_flag) |-> o_port_irq_flag)
		else $error("full flag rose without irq flag");
	master_clk_a: assert property (mst |=> !o_serial_clock_oe_n)
		else $error("master not driving clock pin");
	slave_clk_a: assert property (en && slv |=> o_serial_clock_oe_n)
		else $error("slave driving clock pin");
	off_float_a: assert property (!en |=> o_serial_clock_oe_n && o_data_out_oe_n)
		else $error("disabled port drives a pin");
	desel_float_a: assert property ((en && sel && i_pins.select_n_pin) [*4] |-> o_data_out_oe_n)
		else $error("deselected slave drives data out");
	clk_idle_a: assert property ((mst && !o_busy) [*4] |->
		o_serial_clock_pin == i_cfg.clock_idle_polarity)
		else $error("idle clock level differs from polarity");
endmodule : sync_serial_port_sva
bind sync_serial_port sync_serial_port_sva #(.FIFO_DEPTH(FIFO_DEPTH)) u_sync_serial_port_sva (
	.i_clk_sys, .i_nrst, .i_cfg, .i_buf_wr, .i_buf_wdata, .i_buf_rd, .i_pins,
	.o_port_data_buffer, .o_buffer_full_flag, .o_write_collision_flag, .o_port_irq_flag,
	.o_busy, .o_serial_clock_pin, .o_serial_clock_oe_n, .o_data_out_oe_n);

// *** test/spi_peer_model.sv ***
// behavioural spi peer: msb first, samples on rising clock, shifts on falling
`timescale 1ns/100ps
module spi_peer_model (
	input  wire logic       i_sck,
	input  wire logic       i_sdo,
	input  wire logic       i_sel_n,
	input  wire logic       i_load,
	input  wire logic [7:0] i_tx,
	output logic            o_miso,
	output logic [7:0]      o_rx
);
	logic [7:0] sh_reg;
	logic       bit_reg;
	// deselected peer shows the inverse so a stale level never passes for data
	assign o_miso = i_sel_n ? ~sh_reg[7] : sh_reg[7];
	assign o_rx = sh_reg;
	always @(posedge i_sck) begin
		if (!i_sel_n) bit_reg <= i_sdo;
	end
	always @(negedge i_sck or posedge i_load) begin
		if (i_load) sh_reg <= i_tx;
		else if (!i_sel_n) sh_reg <= {sh_reg[6:0], bit_reg};
	end
endmodule : spi_peer_model

// *** test/sync_serial_port_bench.sv ***
// directed bench: master exchange, collisions, rates, slave select
`timescale 1ns/100ps
`include "sync_serial_port_cfg.svh"
module sync_serial_port_bench;
	logic                            i_clk_sys = 1'b0;
	logic                            i_nrst = 1'b0;
	sync_serial_port_pkg::port_cfg_t i_cfg = '0;
	sync_serial_port_pkg::pin_in_t   i_pins;
	logic [`DATA_W-1:0]              i_baud_reload_reg = 8'h03;
	logic [`DATA_W-1:0]              i_buf_wdata = 8'h00, o_port_data_buffer, p_tx = 8'h00, p_rx;
	logic i_timer2_tick = 1'b0, i_buf_wr = 1'b0, i_buf_rd = 1'b0, i_collision_clr = 1'b0;
	logic i_irq_clr = 1'b0, i_overflow_clr = 1'b0, o_buffer_full_flag, o_write_collision_flag;
	logic o_port_irq_flag, o_receive_overflow, o_busy, o_serial_clock_pin, o_serial_clock_oe_n;
	logic o_data_out_pin, o_data_out_oe_n, p_miso, p_load = 1'b0;
	logic b_sck = 1'b0, b_sdi = 1'b0, b_sel_n = 1'b1, slv = 1'b0;
	int   n_errors = 0, samples_checked = 0, tcnt = 0, n;
	always #50 i_clk_sys = ~i_clk_sys;
	always @(negedge i_clk_sys) begin
		tcnt <= (tcnt == 4) ? 0 : tcnt + 1;
		i_timer2_tick <= (tcnt == 0);
	end
	// the clock wire follows whoever drives it
	assign i_pins = '{o_serial_clock_oe_n ? b_sck : o_serial_clock_pin, slv ? b_sdi : p_miso, b_sel_n};
	sync_serial_port u_sync_serial_port (.i_clk_sys, .i_nrst, .i_cfg, .i_baud_reload_reg,
		.i_timer2_tick, .i_buf_wr, .i_buf_wdata, .i_buf_rd, .i_collision_clr, .i_irq_clr,
		.i_overflow_clr, .i_pins, .o_port_data_buffer, .o_buffer_full_flag,
		.o_write_collision_flag, .o_port_irq_flag, .o_receive_overflow, .o_busy,
		.o_serial_clock_pin, .o_serial_clock_oe_n, .o_data_out_pin, .o_data_out_oe_n);
	spi_peer_model u_spi_peer_model (.i_sck(i_pins.serial_clock_pin), .i_sdo(o_data_out_pin),
		.i_sel_n(b_sel_n), .i_load(p_load), .i_tx(p_tx), .o_miso(p_miso), .o_rx(p_rx));
	task automatic cy(input int c);
		repeat (c) @(negedge i_clk_sys);
	endtask : cy
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic set_cfg(input logic [3:0] m, input logic pol, input logic ovw);
		i_cfg.port_enable_bit = 1'b0;
		cy(1);
		i_cfg = '{1'b0, m, pol, 1'b1, 1'b0, ovw};
		cy(1);
		i_cfg.port_enable_bit = 1'b1;
		cy(1);
	endtask : set_cfg
	task automatic wr(input logic [7:0] d);
		i_buf_wr = 1'b1;
		i_buf_wdata = d;
		cy(1);
		i_buf_wr = 1'b0;
		cy(1);
	endtask : wr
	task automatic rd();
		i_buf_rd = 1'b1;
		cy(1);
		i_buf_rd = 1'b0;
		cy(1);
	endtask : rd
	task automatic wait_idle();
		int g;
		g = 0;
		while (o_busy !== 1'b1 && g < 50) begin
			cy(1);
			g++;
		end
		while (o_busy !== 1'b0 && g < 3000) begin
			cy(1);
			g++;
		end
		if (g >= 3000) n_errors++;
		cy(4);
	endtask : wait_idle
	task automatic half_len(output int c);
		logic l;
		c = 0;
		while (o_serial_clock_pin === i_cfg.clock_idle_polarity && c < 400) begin
			cy(1);
			c++;
		end
		l = o_serial_clock_pin;
		c = 0;
		while (o_serial_clock_pin === l && c < 400) begin
			cy(1);
			c++;
		end
	endtask : half_len
	task automatic sbits(input logic [7:0] d, input int c);
		for (int i = 0; i < c; i++) begin
			b_sdi = d[7-i];
			cy(4);
			b_sck = 1'b1;
			cy(4);
			b_sck = 1'b0;
		end
	endtask : sbits
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : give_verdict
	initial begin
		repeat (40000) @(posedge i_clk_sys);
		n_errors++;
		give_verdict();
	end
	initial begin
		logic [3:0] modes [5];
		logic [7:0] halfs [5];
		modes = '{`MODE_DIV4, `MODE_DIV16, `MODE_DIV64, `MODE_RELOAD, `MODE_TIMER2};
		halfs = '{8'h02, 8'h08, 8'h20, 8'h08, 8'h05};
		cy(12);
		i_nrst = 1'b1;
		cy(3);
		chk("clock oe_n", 8'h01, 8'(o_serial_clock_oe_n));
		set_cfg(`MODE_DIV64, 1'b0, 1'b0);
		p_tx = 8'h3C;
		p_load = 1'b1;
		cy(1);
		p_load = 1'b0;
		b_sel_n = 1'b0;
		wr(8'hA5);
		chk("buffer", 8'hA5, o_port_data_buffer);
		chk("data out", 8'h01, 8'(o_data_out_pin));
		chk("busy", 8'h01, 8'(o_busy));
		chk("clock oe_n", 8'h00, 8'(o_serial_clock_oe_n));
		wait_idle();
		chk("buffer", 8'h3C, o_port_data_buffer);
		chk("full", 8'h01, 8'(o_buffer_full_flag));
		chk("irq", 8'h01, 8'(o_port_irq_flag));
		chk("peer rx", 8'hA5, p_rx);
		rd();
		chk("full", 8'h00, 8'(o_buffer_full_flag));
		wr(8'h11);
		cy(2);
		wr(8'h22);
		chk("collision", 8'h01, 8'(o_write_collision_flag));
		wait_idle();
		chk("buffer", 8'hA5, o_port_data_buffer);
		chk("peer rx", 8'h11, p_rx);
		rd();
		wr(8'h44);
		cy(2);
		chk("busy", 8'h00, 8'(o_busy));
		chk("buffer", 8'hA5, o_port_data_buffer);
		i_collision_clr = 1'b1;
		cy(1);
		i_collision_clr = 1'b0;
		wr(8'h55);
		wait_idle();
		set_cfg(`MODE_DIV64, 1'b0, 1'b1);
		wr(8'h66);
		chk("buffer", 8'h66, o_port_data_buffer);
		wait_idle();
		chk("peer rx", 8'h66, p_rx);
		rd();
		for (int k = 0; k < 5; k++) begin
			set_cfg(modes[k], k[0], 1'b0);
			wr(8'h00);
			half_len(n);
			chk("half period", halfs[k], 8'(n));
			wait_idle();
			chk("idle clock", 8'(k[0]), 8'(o_serial_clock_pin));
			chk("full", 8'h01, 8'(o_buffer_full_flag));
			rd();
		end
		slv = 1'b1;
		set_cfg(`MODE_SLAVE_SEL, 1'b0, 1'b0);
		cy(2);
		chk("clock oe_n", 8'h01, 8'(o_serial_clock_oe_n));
		sbits(8'hFF, 3);
		b_sel_n = 1'b1;
		cy(5);
		chk("data oe_n", 8'h01, 8'(o_data_out_oe_n));
		b_sel_n = 1'b0;
		cy(5);
		sbits(8'hC3, 8);
		cy(8);
		chk("buffer", 8'hC3, o_port_data_buffer);
		rd();
		b_sel_n = 1'b1;
		sbits(8'h0F, 8);
		cy(8);
		chk("full", 8'h00, 8'(o_buffer_full_flag));
		set_cfg(`MODE_SLAVE_FREE, 1'b0, 1'b0);
		for (int j = 0; j < 4; j++) begin
			sbits(8'h81 + 8'(j), 8);
		end
		cy(8);
		chk("overflow", 8'h01, 8'(o_receive_overflow));
		chk("buffer", 8'h81, o_port_data_buffer);
		i_overflow_clr = 1'b1;
		i_irq_clr = 1'b1;
		cy(1);
		i_overflow_clr = 1'b0;
		i_irq_clr = 1'b0;
		cy(1);
		chk("overflow", 8'h00, 8'(o_receive_overflow));
		chk("irq", 8'h00, 8'(o_port_irq_flag));
		rd();
		chk("buffer", 8'h82, o_port_data_buffer);
		chk("full", 8'h01, 8'(o_buffer_full_flag));
		give_verdict();
	end
endmodule : sync_serial_port_bench
